// ==== flash_seq_defines.svh ====
/*
  Timing counts, command codes and field positions for the sector flash host sequencer.
  Assumes a 200 MHz system clock; every cycle count below except SYNC_CYC is derived from it.
*/
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock and pin timing
// ----------------------------------------------------------------------------
`define CLK_MHZ        200
`define T_AS_NS        10
`define T_WP_NS        200
`define T_WPH_NS       200
`define T_ACC_NS       150
`define T_OEHP_NS      150
`define SYNC_CYC       3
// Least times round up
`define AS_CYC         ((`T_AS_NS * `CLK_MHZ + 999) / 1000)
`define WP_CYC         ((`T_WP_NS * `CLK_MHZ + 999) / 1000)
`define WPH_CYC        ((`T_WPH_NS * `CLK_MHZ + 999) / 1000)
`define ACC_CYC        ((`T_ACC_NS * `CLK_MHZ + 999) / 1000)
`define OEHP_CYC       ((`T_OEHP_NS * `CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------------------
// Long times
// ----------------------------------------------------------------------------
`define T_BLW_US       150
`define T_PCL_MS       20
`define T_ID_PAUSE_MS  20
`define T_POWER_MS     20
// Longest time rounds down
`define BLW_CYC        (`T_BLW_US * `CLK_MHZ)
`define PCL_CYC        (`T_PCL_MS * 1000 * `CLK_MHZ)
`define ID_PAUSE_CYC   (`T_ID_PAUSE_MS * 1000 * `CLK_MHZ)
`define POWER_CYC      (`T_POWER_MS * 1000 * `CLK_MHZ)

// ----------------------------------------------------------------------------
// Commands and fields
// ----------------------------------------------------------------------------
`define SECTOR_BYTES   256
`define SECTOR_LSB     8
`define TOGGLE_BIT     6
`define CMD_ADDR_A     15'h5555
`define CMD_ADDR_B     15'h2aaa
`define CODE_FIRST     8'haa
`define CODE_SECOND    8'h55
`define CODE_ID_ENTRY  8'h90

`endif

// ==== flash_seq_pkg.sv ====
/*
  Types of the sector flash host sequencer: operations, sequencer states, bus phases.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package flash_seq_pkg;

  typedef enum logic [2:0]
  {
    op_read      = 3'h0,
    op_program   = 3'h1,
    op_id_entry  = 3'h2,
    op_id_exit   = 3'h3,
    op_lock_low  = 3'h4,
    op_lock_high = 3'h5
  } op_e;

  typedef enum logic [2:0]
  {
    st_power  = 3'b000,
    st_idle   = 3'b001,
    st_cmd    = 3'b011,
    st_load   = 3'b010,
    st_settle = 3'b110,
    st_poll   = 3'b111,
    st_pause  = 3'b101,
    st_finish = 3'b100
  } state_e;

  typedef enum logic [1:0]
  {
    ph_idle    = 2'b00,
    ph_setup   = 2'b01,
    ph_strobe  = 2'b11,
    ph_recover = 2'b10
  } phase_e;

endpackage : flash_seq_pkg

// ==== byte_skid2.sv ====
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock; output data come from a register.
*/
`timescale 1ns/1ps

module byte_skid2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] head_q, head_d;
  logic [WIDTH-1:0] tail_q, tail_d;
  logic [1:0]       fill_q, fill_d;
  logic             push;
  logic             pop;

  assign in_ready  = (fill_q != 2'h2);
  assign out_valid = (fill_q != 2'h0);
  assign out_data  = head_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    head_d = head_q;
    tail_d = tail_q;
    fill_d = fill_q;
    if (pop)
    begin
      head_d = tail_q;
    end
    if (push)
    begin
      if (fill_q == 2'h0 || (fill_q == 2'h1 && pop))
      begin
        head_d = in_data;
      end
      else
      begin
        tail_d = in_data;
      end
    end
    fill_d = fill_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      head_q <= '0;
      tail_q <= '0;
      fill_q <= 2'h0;
    end
    else
    begin
      head_q <= head_d;
      tail_q <= tail_d;
      fill_q <= fill_d;
    end
  end

endmodule : byte_skid2

// ==== sector_flash_host.sv ====
/*
  Host controller for a byte-wide sector flash: command sequences, sector loads,
  toggle polling, identification mode and boot block lockout, over the flash pins.
  Assumes the flash pins are wired by the testbench from the enables; dq_in is asynchronous.
*/
`timescale 1ns/1ps
`include "flash_seq_defines.svh"

module sector_flash_host #(
  parameter int unsigned BLW_CYC      = `BLW_CYC,
  parameter int unsigned LOAD_GUARD   = `BLW_CYC / 2,
  parameter int unsigned PCL_CYC      = `PCL_CYC,
  parameter int unsigned ID_PAUSE_CYC = `ID_PAUSE_CYC,
  parameter int unsigned POWER_CYC    = `POWER_CYC,
  parameter logic [7:0]  PROG_CMD     = 8'ha0,
  parameter logic [7:0]  EXIT_CMD     = 8'hf0,
  parameter logic [7:0]  LOCK_PREFIX  = 8'h80,
  parameter logic [7:0]  LOCK_LOW     = 8'h40,
  parameter logic [7:0]  LOCK_HIGH    = 8'h41
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire flash_seq_pkg::op_e cmd_op,
  input  wire logic [18:0]        cmd_addr,
  input  wire logic               wr_valid,
  output logic                    wr_ready,
  input  wire logic [7:0]         wr_data,
  output logic                    rd_valid,
  output logic [7:0]              rd_data,
  output logic                    busy,
  output logic                    done,
  output logic                    error,
  output logic                    load_short,
  output logic [18:0]             flash_addr,
  output logic                    flash_ce_n,
  output logic                    flash_oe_n,
  output logic                    flash_we_n,
  input  wire logic [7:0]         dq_in,
  output logic [7:0]              dq_out,
  output logic                    dq_oe_n
);
  import flash_seq_pkg::*;

  // --------------------------------------------------------------------------
  // Command sequence table
  // --------------------------------------------------------------------------
  function automatic logic [22:0] seq_word(input op_e op, input logic [2:0] i);
    logic [7:0] third;
    third = PROG_CMD;
    unique case (op)
      op_id_entry:              third = `CODE_ID_ENTRY;
      op_id_exit:               third = EXIT_CMD;
      op_lock_low, op_lock_high: third = LOCK_PREFIX;
      default:                  third = PROG_CMD;
    endcase
    unique case (i)
      3'h0, 3'h3: seq_word = {`CMD_ADDR_A, `CODE_FIRST};
      3'h1, 3'h4: seq_word = {`CMD_ADDR_B, `CODE_SECOND};
      3'h2:       seq_word = {`CMD_ADDR_A, third};
      default:    seq_word = {`CMD_ADDR_A, (op == op_lock_high) ? LOCK_HIGH : LOCK_LOW};
    endcase
  endfunction : seq_word

  function automatic logic [2:0] seq_len(input op_e op);
    seq_len = (op == op_lock_low || op == op_lock_high) ? 3'h6 : 3'h3;
  endfunction : seq_len

  // --------------------------------------------------------------------------
  // Data pin synchroniser
  // --------------------------------------------------------------------------
  logic [7:0] s1_q, s2_q, s3_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
    end
    else
    begin
      s1_q <= dq_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // --------------------------------------------------------------------------
  // Write data buffer
  // --------------------------------------------------------------------------
  logic       buf_valid;
  logic       buf_ready;
  logic [7:0] buf_data;

  byte_skid2 #(
    .WIDTH     (8)
  ) u_buf (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  // --------------------------------------------------------------------------
  // Sequencer and bus engine
  // --------------------------------------------------------------------------
  state_e      st_q, st_d;
  phase_e      ph_q, ph_d;
  op_e         op_q, op_d;
  logic [18:0] addr_q, addr_d;
  logic [2:0]  idx_q, idx_d;
  logic [8:0]  cnt_q, cnt_d;
  logic [7:0]  tmr_q, tmr_d;
  logic [31:0] long_q, long_d;
  logic        wr_q, wr_d;
  logic [18:0] pa_q, pa_d;
  logic [7:0]  dout_q, dout_d;
  logic        ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, dq_oe_n_q, dq_oe_n_d;
  logic [7:0]  rbyte_q, rbyte_d, rd_data_q, rd_data_d;
  logic        rd_valid_q, rd_valid_d, done_q, done_d, err_q, err_d, short_q, short_d;
  logic        tog_q, tog_d, first_q, first_d, have_q, have_d;
  logic        launch, l_wr;
  logic [18:0] l_addr;
  logic [7:0]  l_data;
  logic [22:0] sw;

  assign cmd_ready  = (st_q == st_idle);
  assign busy       = (st_q != st_idle);
  assign rd_valid   = rd_valid_q;
  assign rd_data    = rd_data_q;
  assign done       = done_q;
  assign error      = err_q;
  assign load_short = short_q;
  assign flash_addr = pa_q;
  assign flash_ce_n = ce_n_q;
  assign flash_oe_n = oe_n_q;
  assign flash_we_n = we_n_q;
  assign dq_out     = dout_q;
  assign dq_oe_n    = dq_oe_n_q;

  always_comb
  begin
    st_d = st_q; ph_d = ph_q; op_d = op_q; addr_d = addr_q; idx_d = idx_q; cnt_d = cnt_q;
    tmr_d = tmr_q; long_d = long_q; wr_d = wr_q; pa_d = pa_q; dout_d = dout_q;
    ce_n_d = ce_n_q; oe_n_d = oe_n_q; we_n_d = we_n_q; dq_oe_n_d = dq_oe_n_q;
    rbyte_d = rbyte_q; rd_data_d = rd_data_q; rd_valid_d = 1'b0; done_d = 1'b0;
    err_d = err_q; short_d = short_q; tog_d = tog_q; first_d = first_q; have_d = have_q;
    launch = 1'b0; l_wr = 1'b0; l_addr = 19'h00000; l_data = 8'h00; buf_ready = 1'b0;
    sw = seq_word(op_q, idx_q);

    unique case (st_q)
      st_power:
      begin
        long_d = long_q + 32'h1;
        if (long_q >= POWER_CYC)
        begin
          st_d = st_idle;
        end
      end
      st_idle:
      begin
        if (cmd_valid)
        begin
          op_d = cmd_op; addr_d = cmd_addr; idx_d = 3'h0; cnt_d = 9'h000;
          err_d = 1'b0; short_d = 1'b0; long_d = 32'h0;
          if (cmd_op == op_read)
          begin
            launch = 1'b1; l_addr = cmd_addr;
            st_d = st_finish;
          end
          else
          begin
            st_d = st_cmd;
          end
        end
      end
      st_cmd:
      begin
        if (ph_q == ph_idle)
        begin
          if (idx_q == seq_len(op_q))
          begin
            long_d = 32'h0;
            if (op_q == op_program)
            begin
              st_d = st_load;
            end
            else if (op_q == op_id_entry)
            begin
              st_d = st_pause;
            end
            else
            begin
              done_d = 1'b1; st_d = st_idle;
            end
          end
          else
          begin
            // Upper address bits held low during command writes
            launch = 1'b1; l_wr = 1'b1; l_addr = {4'h0, sw[22:8]}; l_data = sw[7:0];
            idx_d = idx_q + 3'h1;
          end
        end
      end
      st_load:
      begin
        long_d = long_q + 32'h1;
        if (ph_q == ph_idle)
        begin
          if (cnt_q == 9'(`SECTOR_BYTES))
          begin
            st_d = st_settle; long_d = 32'h0;
          end
          else if (buf_valid)
          begin
            buf_ready = 1'b1; launch = 1'b1; l_wr = 1'b1; l_data = buf_data; long_d = 32'h0;
            l_addr = {addr_q[18:`SECTOR_LSB], cnt_q[7:0]};
            cnt_d = cnt_q + 9'h001;
          end
          else if (long_q >= LOAD_GUARD)
          begin
            // Starved stream: stop well inside the window, tail bytes become undefined
            short_d = 1'b1; st_d = st_settle; long_d = 32'h0;
          end
        end
      end
      st_settle:
      begin
        // Polling before the window expires would see a still cycle and report done early
        long_d = long_q + 32'h1;
        if (long_q >= BLW_CYC)
        begin
          st_d = st_poll; long_d = 32'h0; first_d = 1'b0; have_d = 1'b0;
        end
      end
      st_poll:
      begin
        long_d = long_q + 32'h1;
        if (ph_q == ph_idle)
        begin
          if (have_q && first_q && rbyte_q[`TOGGLE_BIT] == tog_q)
          begin
            done_d = 1'b1; st_d = st_idle; have_d = 1'b0;
          end
          else if (have_q && long_q >= PCL_CYC)
          begin
            err_d = 1'b1; done_d = 1'b1; st_d = st_idle; have_d = 1'b0;
          end
          else
          begin
            if (have_q)
            begin
              tog_d = rbyte_q[`TOGGLE_BIT]; first_d = 1'b1;
            end
            launch = 1'b1; have_d = 1'b1;
            l_addr = {addr_q[18:`SECTOR_LSB], 8'h00};
          end
        end
      end
      st_pause:
      begin
        long_d = long_q + 32'h1;
        if (long_q >= ID_PAUSE_CYC)
        begin
          done_d = 1'b1; st_d = st_idle;
        end
      end
      st_finish:
      begin
        if (ph_q == ph_idle)
        begin
          rd_valid_d = 1'b1; rd_data_d = rbyte_q; done_d = 1'b1; st_d = st_idle;
        end
      end
    endcase

    unique case (ph_q)
      ph_idle:
      begin
        if (launch)
        begin
          ph_d = ph_setup; tmr_d = 8'(`AS_CYC - 1); wr_d = l_wr; pa_d = l_addr; dout_d = l_data;
          ce_n_d = 1'b0; oe_n_d = 1'b1; dq_oe_n_d = !l_wr;
        end
      end
      ph_setup:
      begin
        tmr_d = tmr_q - 8'h01;
        if (tmr_q == 8'h00)
        begin
          ph_d = ph_strobe;
          tmr_d = wr_q ? 8'(`WP_CYC - 1) : 8'(`ACC_CYC + `SYNC_CYC - 1);
          we_n_d = !wr_q;
          oe_n_d = wr_q;
        end
      end
      ph_strobe:
      begin
        tmr_d = (tmr_q == 8'h00) ? 8'h00 : tmr_q - 8'h01;
        // A read waits until the synchronised data are stable
        if (tmr_q == 8'h00 && (wr_q || s2_q == s3_q))
        begin
          ph_d = ph_recover; we_n_d = 1'b1; oe_n_d = 1'b1;
          tmr_d = wr_q ? 8'(`WPH_CYC - 1) : 8'(`OEHP_CYC - 1);
          if (!wr_q)
          begin
            rbyte_d = s3_q;
          end
        end
      end
      ph_recover:
      begin
        tmr_d = tmr_q - 8'h01;
        if (tmr_q == 8'h00)
        begin
          ph_d = ph_idle; ce_n_d = 1'b1; dq_oe_n_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= st_power; ph_q <= ph_idle; op_q <= op_read; addr_q <= 19'h00000;
      idx_q <= 3'h0; cnt_q <= 9'h000; tmr_q <= 8'h00; long_q <= 32'h0; wr_q <= 1'b0;
      pa_q <= 19'h00000; dout_q <= 8'h00; ce_n_q <= 1'b1; oe_n_q <= 1'b1; we_n_q <= 1'b1;
      dq_oe_n_q <= 1'b1; rbyte_q <= 8'h00; rd_data_q <= 8'h00; rd_valid_q <= 1'b0;
      done_q <= 1'b0; err_q <= 1'b0; short_q <= 1'b0; tog_q <= 1'b0; first_q <= 1'b0;
      have_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d; ph_q <= ph_d; op_q <= op_d; addr_q <= addr_d;
      idx_q <= idx_d; cnt_q <= cnt_d; tmr_q <= tmr_d; long_q <= long_d; wr_q <= wr_d;
      pa_q <= pa_d; dout_q <= dout_d; ce_n_q <= ce_n_d; oe_n_q <= oe_n_d; we_n_q <= we_n_d;
      dq_oe_n_q <= dq_oe_n_d; rbyte_q <= rbyte_d; rd_data_q <= rd_data_d; rd_valid_q <= rd_valid_d;
      done_q <= done_d; err_q <= err_d; short_q <= short_d; tog_q <= tog_d; first_q <= first_d;
      have_q <= have_d;
    end
  end

endmodule : sector_flash_host

// ==== flash_host_props.sv ====
/*
  Checker of the sector flash host block: command port and flash pins.
  Assumes it is bound into sector_flash_host and sees only its ports.
*/
`timescale 1ns/1ps
module flash_host_props
  import flash_seq_pkg::*;
#(
  parameter int unsigned BLW_CYC      = 200,
  parameter int unsigned ID_PAUSE_CYC = 50,
  parameter int unsigned POWER_CYC    = 20
) (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               cmd_valid,
  input wire logic               cmd_ready,
  input wire flash_seq_pkg::op_e cmd_op,
  input wire logic [18:0]        cmd_addr,
  input wire logic               done,
  input wire logic [18:0]        flash_addr,
  input wire logic               flash_ce_n,
  input wire logic               flash_oe_n,
  input wire logic               flash_we_n,
  input wire logic [7:0]         dq_out,
  input wire logic               dq_oe_n
);
  import flash_seq_pkg::*;
  logic        we_p;
  logic        oe_p;
  int unsigned wcnt_q;
  int unsigned gap_q;
  int unsigned pw_q;
  op_e         op_q;
  logic [10:0] sec_q;
  logic        wr_ev;
  logic        rd_ev;
  logic        take;
  assign wr_ev = flash_we_n && !we_p && !flash_ce_n;
  assign rd_ev = !flash_oe_n && oe_p;
  assign take  = cmd_valid && cmd_ready;
  // ---------------------------------------------------------------
  // Write counting since the command was taken
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      we_p   <= 1'b1;
      oe_p   <= 1'b1;
      wcnt_q <= 0;
      gap_q  <= 0;
      pw_q   <= 0;
      op_q   <= op_read;
      sec_q  <= '0;
    end
    else
    begin
      we_p   <= flash_we_n;
      oe_p   <= flash_oe_n;
      pw_q   <= (pw_q < POWER_CYC) ? pw_q + 1 : pw_q;
      gap_q  <= wr_ev ? 0 : gap_q + 1;
      wcnt_q <= take ? 0 : wcnt_q + wr_ev;
      op_q   <= take ? cmd_op : op_q;
      sec_q  <= take ? cmd_addr[18:8] : sec_q;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_power_wait: assert property (
    pw_q + 1 < POWER_CYC |-> flash_ce_n && !cmd_ready) else $error("early operation");
  chk_first_unlock: assert property (
    wr_ev && wcnt_q == 0 && op_q != op_read |-> flash_addr[14:0] == 15'h5555 && dq_out == 8'haa)
    else $error("first command write wrong");
  chk_second_unlock: assert property (
    wr_ev && wcnt_q == 1 |-> flash_addr[14:0] == 15'h2aaa && dq_out == 8'h55) else $error("second write wrong");
  chk_id_code: assert property (
    wr_ev && wcnt_q == 2 && op_q == op_id_entry |-> flash_addr[14:0] == 15'h5555 && dq_out == 8'h90)
    else $error("id entry code wrong");
  chk_same_sector: assert property (
    wr_ev && op_q == op_program && wcnt_q >= 3 |-> flash_addr[18:8] == sec_q) else $error("sector moved");
  chk_byte_order: assert property (
    wr_ev && op_q == op_program && wcnt_q >= 3 |-> flash_addr[7:0] == 8'(wcnt_q - 3)) else $error("byte order");
  chk_load_gap: assert property (
    wr_ev && op_q == op_program && wcnt_q >= 4 |-> gap_q < BLW_CYC) else $error("load gap too long");
  chk_poll_quiet: assert property (
    rd_ev && op_q == op_program && wcnt_q >= 3 |-> gap_q >= BLW_CYC) else $error("poll before window");
  chk_poll_addr: assert property (
    rd_ev && op_q == op_program && wcnt_q >= 3 |-> flash_addr == {sec_q, 8'h00}) else $error("poll address");
  chk_id_pause: assert property (
    done && op_q == op_id_entry |-> gap_q >= ID_PAUSE_CYC) else $error("id pause short");
  chk_write_strobe: assert property (
    !flash_we_n |-> flash_oe_n && !flash_ce_n && !dq_oe_n) else $error("write strobe qualifiers");
  cover property (done && op_q == op_program);
  cover property (done && op_q == op_id_entry);
  cover property (done && op_q == op_lock_high);
endmodule : flash_host_props

bind sector_flash_host flash_host_props #(.BLW_CYC(BLW_CYC), .ID_PAUSE_CYC(ID_PAUSE_CYC), .POWER_CYC(POWER_CYC))
  u_props (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
  .cmd_addr(cmd_addr), .done(done), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

// ==== flash_dev_model.sv ====
/*
  Behavioural sector flash on the host block's pins.
  Assumes pins sampled on clk; nrst stands for power-up.
*/
`timescale 1ns/1ps
module flash_dev_model #(
  parameter int unsigned BLW   = 190,
  parameter int unsigned PROG  = 300,
  parameter logic [7:0]  MAKER = 8'h3c, // Arbitrary value
  parameter logic [7:0]  PART  = 8'h5a  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [18:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  dq_w,
  output logic [7:0]       dq_r,
  output logic             viol
);
  logic [7:0]   mem [0:524287];
  logic [7:0]   lbuf [0:255];
  logic [255:0] lval;
  logic [10:0]  sec;
  logic [2:0]   step;
  logic [1:0]   lk;
  logic         idm, ld, pg, tog, b7, we_p, oe_p, ce_p;
  int unsigned  cnt;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      {step, lk, idm, ld, pg, tog, b7, viol} <= '0;
      {we_p, oe_p, ce_p} <= 3'b111;
      cnt <= 0;
      dq_r <= 8'h00;
    end
    else
    begin
      we_p <= we_n;
      oe_p <= oe_n;
      ce_p <= ce_n;
      if (!oe_n && !ce_n && (oe_p || ce_p))
        tog <= ~tog;
      // Bus outside a read cycle shows a changing pattern: the last byte and its complement in turn
      if (!ce_n && !oe_n && we_n)
        dq_r <= (idm && addr[18:1] == 0) ? (addr[0] ? PART : MAKER)
              : pg ? {~b7, tog, 6'h00} : mem[addr];
      else
        dq_r <= ~dq_r;
      if (we_n && !we_p && !ce_n)
      begin
        cnt <= 0;
        if (!oe_n)
          viol <= 1'b1;
        if (ld)
        begin
          if (lval != 0 && addr[18:8] != sec)
            viol <= 1'b1;
          sec <= addr[18:8];
          lbuf[addr[7:0]] <= dq_w;
          lval[addr[7:0]] <= 1'b1;
          b7 <= dq_w[7];
        end
        else if (!pg)
          case (step)
            3'd0, 3'd3: step <= (addr[14:0] == 15'h5555 && dq_w == 8'haa) ? step + 1 : 3'd0;
            3'd1, 3'd4: step <= (addr[14:0] == 15'h2aaa && dq_w == 8'h55) ? step + 1 : 3'd0;
            3'd2:
            begin
              step <= (dq_w == 8'h80) ? 3'd3 : 3'd0;
              idm  <= (dq_w == 8'h90) ? 1'b1 : (dq_w == 8'hf0) ? 1'b0 : idm;
              ld   <= (dq_w == 8'ha0);
              lval <= '0;
            end
            default:
            begin
              step <= 3'd0;
              lk   <= lk | {dq_w == 8'h41, dq_w == 8'h40};
            end
          endcase
      end
      else if (ld && cnt == BLW)
      begin
        ld  <= 1'b0;
        pg  <= 1'b1;
        cnt <= 0;
        if (!(lk[0] && sec[10:6] == 0) && !(lk[1] && &sec[10:6]))
          for (int i = 0; i < 256; i++)
            mem[{sec, 8'(i)}] = lval[i] ? lbuf[i] : 8'hxx;
      end
      else if (pg && cnt == PROG)
        pg <= 1'b0;
      else
        cnt <= cnt + 1;
    end
  end
endmodule : flash_dev_model

// ==== sector_flash_host_test.sv ====
/*
  Self-checking bench of the sector flash host block.
  Assumes flash_dev_model on the pins and the props checker bound in.
*/
`timescale 1ns/1ps
module sector_flash_host_test;
  import flash_seq_pkg::*;
  localparam int unsigned POWER = 20;
  localparam int unsigned BLW = 200, GUARD = 100, PCL = 2000, ID_PAUSE = 50, DEV_BLW = 190, DEV_PROG = 300;
  localparam logic [7:0]  MAKER = 8'h3c, PART = 8'h5a; // Arbitrary values
  logic        clk = 0, nrst = 0, cmd_valid = 0, wr_valid = 0, acc = 0;
  op_e         cmd_op = op_read;
  logic [18:0] cmd_addr = '0, fa;
  logic [7:0]  wr_data = '0, got, rdd, dq_out, dq_r, bus;
  logic        cmd_ready, wr_ready, rd_valid, busy, done, error, load_short;
  logic        ce_n, oe_n, we_n, dq_oe_n, viol;
  logic [7:0]  exp_mem [int];
  logic [7:0]  wq [$];
  int          miscompares = 0, num_checks = 0;
  assign bus = dq_oe_n ? dq_r : dq_out;
  always #2.5 clk = ~clk;
  sector_flash_host #(.BLW_CYC(BLW), .LOAD_GUARD(GUARD), .PCL_CYC(PCL), .ID_PAUSE_CYC(ID_PAUSE), .POWER_CYC(POWER))
    uut (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rdd), .busy(busy), .done(done), .error(error), .load_short(load_short), .flash_addr(fa),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .dq_in(bus), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
  flash_dev_model #(.BLW(DEV_BLW), .PROG(DEV_PROG), .MAKER(MAKER), .PART(PART))
    dev (.clk(clk), .nrst(nrst), .addr(fa), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_w(bus), .dq_r(dq_r),
    .viol(viol));
  // ---------------------------------------------------------------
  // Byte stream with random stalls; a byte is held until taken
  // ---------------------------------------------------------------
  always @(posedge clk)
    acc <= wr_valid && wr_ready;
  always @(negedge clk)
  begin
    if (acc)
      void'(wq.pop_front());
    if (acc || !wr_valid)
    begin
      wr_valid = wq.size() > 0 && $urandom_range(3) != 0;
      wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
    end
  end
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : check
  task automatic run(input op_e op, input logic [18:0] a);
    int n;
    n = 0;
    @(negedge clk);
    cmd_op = op;
    cmd_addr = a;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    check({7'h0, busy}, 8'h01);
    while (done !== 1'b1 && n < 40000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 40000)
    begin
      miscompares++;
      report_and_stop();
    end
    got = rdd;
    check({7'h0, error}, 8'h00);
    check({7'h0, busy}, 8'h00);
  endtask : run
  task automatic rd(input logic [18:0] a, input logic [7:0] e);
    run(op_read, a);
    check({7'h0, rd_valid}, 8'h01);
    check(got, e);
  endtask : rd
  task automatic prog(input logic [10:0] s, input int n, input bit keep);
    logic [7:0] b;
    for (int i = 0; i < n; i++)
    begin
      b = 8'($urandom);
      wq.push_back(b);
      if (keep)
        exp_mem[{s, 8'(i)}] = b;
    end
    run(op_program, {s, 8'($urandom)});
    check({7'h0, load_short}, {7'h0, n < 256});
  endtask : prog
  initial
  begin
    int n;
    logic [18:0] ra;
    n = $urandom(32'h4ba01c10);
    repeat (2) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    check({7'h0, cmd_ready}, 8'h00);
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 100)
    begin
      miscompares++;
      report_and_stop();
    end
    check({7'h0, n >= POWER}, 8'h01);
    prog(11'h7c5, 256, 1);
    for (int i = 0; i < 6; i++)
    begin
      ra = {11'h7c5, (i < 2) ? 8'(i * 255) : 8'($urandom)};
      rd(ra, exp_mem[ra]);
    end
    run(op_id_entry, 19'h0);
    rd(19'h0, MAKER);
    rd(19'h1, PART);
    run(op_id_exit, 19'h0);
    rd({11'h7c5, 8'h07}, exp_mem[{11'h7c5, 8'h07}]);
    run(op_lock_low, 19'h0);
    prog(11'h123, 12, 1);
    rd({11'h123, 8'd11}, exp_mem[{11'h123, 8'd11}]);
    run(op_lock_high, 19'h0);
    prog(11'h7c5, 12, 0);
    rd({11'h7c5, 8'h03}, exp_mem[{11'h7c5, 8'h03}]);
    check({7'h0, viol}, 8'h00);
    report_and_stop();
  end
endmodule : sector_flash_host_test
